// File: src/dep_select_defs.vh
/*
 Register offsets, field positions and reset values for the output
 dependency selection block. Assumes inclusion by bare name.
*/
`ifndef DEP_SELECT_DEFS_VH
`define DEP_SELECT_DEFS_VH

`define OUT6_DET_SEL_ADDR 8'h19
`define OUT6_LOGIC_SEL_ADDR 8'h1a
`define OUT7_DET_SEL_ADDR 8'h1c
`define OUT7_LOGIC_SEL_ADDR 8'h1d
`define OUT8_DET_SEL_ADDR 8'h1f
`define OUT8_LOGIC_SEL_ADDR 8'h20

`define OUT6_DET_NV_ADDR 8'h99
`define OUT6_LOGIC_NV_ADDR 8'h9a
`define OUT7_DET_NV_ADDR 8'h9c
`define OUT7_LOGIC_NV_ADDR 8'h9d
`define OUT8_DET_NV_ADDR 8'h9f
`define OUT8_LOGIC_NV_ADDR 8'ha0

`define LOGIC_WDOG_BIT 0
`define LOGIC_GPI_LSB 1
`define LOGIC_GPI_MSB 4
`define LOGIC_MR_BIT 5
`define LOGIC_USED_MASK 8'h3f

`define DET_SEL_RESET 8'h00
`define LOGIC_SEL_RESET 8'h00

`endif

// File: src/dep_source_mux.v
/*
 Combines the fault sources of one sequenced output under its two
 dependency selection registers. Assumes all inputs are synchronous;
 detectors and watchdog are high in fault, logic inputs and manual reset low.
*/
`timescale 1ns/100ps
`include "dep_select_defs.vh"

module dep_source_mux (
  input wire [7:0] det_sel,
  input wire [7:0] logic_sel,
  input wire [7:0] undervoltage,
  input wire watchdog_timeout,
  input wire [3:0] general_logic_input_n,
  input wire manual_reset_n,
  output wire assert_req
);
  wire [7:0] det_hits;
  wire wdog_hit;
  wire [3:0] gpi_hits;
  wire mr_hit;

  // Detector i follows bit i
  assign det_hits = det_sel & undervoltage; // [RULE1] [RULE5]
  assign wdog_hit = logic_sel[`LOGIC_WDOG_BIT] & watchdog_timeout; // [RULE2]
  // Logic inputs active low
  assign gpi_hits = logic_sel[`LOGIC_GPI_MSB:`LOGIC_GPI_LSB] &
                    ~general_logic_input_n; // [RULE3] [RULE5]
  assign mr_hit = logic_sel[`LOGIC_MR_BIT] & ~manual_reset_n; // [RULE4]
  assign assert_req = (|det_hits) | wdog_hit | (|gpi_hits) | mr_hit; // [RULE9]
endmodule

// File: src/output_dependency_select.v
/*
 Dependency selection registers and assertion requests for the sixth,
 seventh and eighth sequenced outputs. Assumes a byte-wide register
 port from the two-wire configuration engine, which also handles the
 nonvolatile copies by issuing loads at their addresses.
 Copy addresses reach the same flops as the working addresses. Detector
 and watchdog inputs are high in fault; the logic inputs and the manual
 reset are active low. All inputs are synchronous to the clock.
*/
// Contract
// RULE1 - First register bits 0 to 7 select detectors 1 to 8.
// RULE2 - Second register bit 0 selects the watchdog timeout.
// RULE3 - Second register bits 1 to 4 select logic inputs 1 to 4.
// RULE4 - Second register bit 5 asserts the output while manual reset is low.
// RULE5 - A cleared bit makes the output ignore that source entirely.
// RULE6 - Output six uses registers 19h and 1Ah, copies at 99h and 9Ah.
// RULE7 - Output seven uses registers 1Ch and 1Dh, copies at 9Ch and 9Dh.
// RULE8 - Output eight uses registers 1Fh and 20h, copies at 9Fh and A0h.
// RULE9 - The request is the OR of every enabled source in its fault state.
// RULE10 - Second register bits 7 and 6 ignore writes and read as zero.
`timescale 1ns/100ps
`include "dep_select_defs.vh"

module output_dependency_select (
  input wire clock,
  input wire rst,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_hit,
  input wire [7:0] undervoltage,
  input wire watchdog_timeout,
  input wire [3:0] general_logic_input_n,
  input wire manual_reset_n,
  output reg sequenced_output_six,
  output reg sequenced_output_seven,
  output reg sequenced_output_eight
);
  reg [7:0] det6_q;
  reg [7:0] det7_q;
  reg [7:0] det8_q;
  reg [7:0] log6_q;
  reg [7:0] log7_q;
  reg [7:0] log8_q;
  reg [7:0] det6_d;
  reg [7:0] det7_d;
  reg [7:0] det8_d;
  reg [7:0] log6_d;
  reg [7:0] log7_d;
  reg [7:0] log8_d;
  reg [7:0] rdata_d;
  reg hit_d;
  reg [2:0] out_d;
  wire req6;
  wire req7;
  wire req8;

  // Map a nonvolatile copy address onto its working register address
  function [7:0] work_addr;
    input [7:0] a;
    begin
      case (a)
        `OUT6_DET_NV_ADDR: work_addr = `OUT6_DET_SEL_ADDR;
        `OUT6_LOGIC_NV_ADDR: work_addr = `OUT6_LOGIC_SEL_ADDR;
        `OUT7_DET_NV_ADDR: work_addr = `OUT7_DET_SEL_ADDR;
        `OUT7_LOGIC_NV_ADDR: work_addr = `OUT7_LOGIC_SEL_ADDR;
        `OUT8_DET_NV_ADDR: work_addr = `OUT8_DET_SEL_ADDR;
        `OUT8_LOGIC_NV_ADDR: work_addr = `OUT8_LOGIC_SEL_ADDR;
        default: work_addr = a;
      endcase
    end
  endfunction

  // One-hot codes of the six working registers
  localparam SEL_DET6 = 6'h01;
  localparam SEL_LOG6 = 6'h02;
  localparam SEL_DET7 = 6'h04;
  localparam SEL_LOG7 = 6'h08;
  localparam SEL_DET8 = 6'h10;
  localparam SEL_LOG8 = 6'h20;

  // One-hot pick of the working register an access lands on
  function [5:0] reg_select;
    input [7:0] a;
    begin
      case (a)
        `OUT6_DET_SEL_ADDR: reg_select = SEL_DET6;
        `OUT6_LOGIC_SEL_ADDR: reg_select = SEL_LOG6;
        `OUT7_DET_SEL_ADDR: reg_select = SEL_DET7;
        `OUT7_LOGIC_SEL_ADDR: reg_select = SEL_LOG7;
        `OUT8_DET_SEL_ADDR: reg_select = SEL_DET8;
        `OUT8_LOGIC_SEL_ADDR: reg_select = SEL_LOG8;
        default: reg_select = 6'h00;
      endcase
    end
  endfunction

  wire [7:0] waddr = work_addr(reg_addr);
  wire [7:0] wlog = reg_wdata & `LOGIC_USED_MASK; // [RULE10]
  wire [5:0] acc_sel = reg_select(waddr);
  wire wr_go = clk_en & reg_wr;

  // Next selection values; unmapped writes change nothing
  always @* begin
    det6_d = det6_q;
    log6_d = log6_q;
    det7_d = det7_q;
    log7_d = log7_q;
    det8_d = det8_q;
    log8_d = log8_q;
    if (wr_go) begin
      case (acc_sel)
        SEL_DET6: det6_d = reg_wdata; // [RULE6]
        SEL_LOG6: log6_d = wlog; // [RULE6]
        SEL_DET7: det7_d = reg_wdata; // [RULE7]
        SEL_LOG7: log7_d = wlog; // [RULE7]
        SEL_DET8: det8_d = reg_wdata; // [RULE8]
        SEL_LOG8: log8_d = wlog; // [RULE8]
        default: ;
      endcase
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      det6_q <= `DET_SEL_RESET;
      det7_q <= `DET_SEL_RESET;
      det8_q <= `DET_SEL_RESET;
      log6_q <= `LOGIC_SEL_RESET;
      log7_q <= `LOGIC_SEL_RESET;
      log8_q <= `LOGIC_SEL_RESET;
    end else begin
      det6_q <= det6_d;
      det7_q <= det7_d;
      det8_q <= det8_d;
      log6_q <= log6_d;
      log7_q <= log7_d;
      log8_q <= log8_d;
    end
  end

  // Read next values; unmapped addresses read zero with no hit
  always @* begin
    rdata_d = reg_rdata;
    hit_d = 1'b0;
    if (reg_rd) begin
      hit_d = |acc_sel;
      case (acc_sel)
        SEL_DET6: rdata_d = det6_q;
        SEL_LOG6: rdata_d = log6_q; // [RULE10]
        SEL_DET7: rdata_d = det7_q;
        SEL_LOG7: rdata_d = log7_q; // [RULE10]
        SEL_DET8: rdata_d = det8_q;
        SEL_LOG8: rdata_d = log8_q; // [RULE10]
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Registered read data holds until the next read
  always @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else if (clk_en) begin
      reg_rdata <= rdata_d;
      reg_hit <= hit_d;
    end
  end

  dep_source_mux mux6 (
    .det_sel(det6_q),
    .logic_sel(log6_q),
    .undervoltage(undervoltage),
    .watchdog_timeout(watchdog_timeout),
    .general_logic_input_n(general_logic_input_n),
    .manual_reset_n(manual_reset_n),
    .assert_req(req6)
  );

  dep_source_mux mux7 (
    .det_sel(det7_q),
    .logic_sel(log7_q),
    .undervoltage(undervoltage),
    .watchdog_timeout(watchdog_timeout),
    .general_logic_input_n(general_logic_input_n),
    .manual_reset_n(manual_reset_n),
    .assert_req(req7)
  );

  dep_source_mux mux8 (
    .det_sel(det8_q),
    .logic_sel(log8_q),
    .undervoltage(undervoltage),
    .watchdog_timeout(watchdog_timeout),
    .general_logic_input_n(general_logic_input_n),
    .manual_reset_n(manual_reset_n),
    .assert_req(req8)
  );

  // Next assertion requests, held while the clock enable is low
  always @* begin
    out_d = {sequenced_output_eight, sequenced_output_seven,
      sequenced_output_six};
    if (clk_en) begin
      out_d = {req8, req7, req6}; // [RULE9]
    end
  end

  // Registered assertion requests
  always @(posedge clock) begin
    if (rst) begin
      sequenced_output_six <= 1'b0;
      sequenced_output_seven <= 1'b0;
      sequenced_output_eight <= 1'b0;
    end else begin
      sequenced_output_six <= out_d[0];
      sequenced_output_seven <= out_d[1];
      sequenced_output_eight <= out_d[2];
    end
  end
endmodule

// File: bench/output_dependency_select_checker.sv
/* Port checker for output_dependency_select.
 Assumes it is bound to the design top and sees only its ports. */
`timescale 1ns/100ps
module output_dependency_select_checker (
  input wire clock,
  input wire rst,
  input wire clk_en,
  input wire reg_wr,
  input wire reg_rd,
  input wire reg_hit,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [7:0] undervoltage,
  input wire watchdog_timeout,
  input wire manual_reset_n,
  input wire [3:0] general_logic_input_n,
  input wire sequenced_output_six,
  input wire sequenced_output_seven,
  input wire sequenced_output_eight
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire rd = reg_rd && clk_en;
  wire [6:0] lo = reg_addr[6:0];
  wire map = lo inside {7'h19, 7'h1a, 7'h1c, 7'h1d, 7'h1f, 7'h20};
  wire [2:0] outs = {sequenced_output_eight, sequenced_output_seven,
    sequenced_output_six};
  wire quiet = undervoltage == 8'h00 && !watchdog_timeout &&
    &general_logic_input_n && manual_reset_n;
  chk_unmapped_zero:
    assert property (rd && !map |=> !reg_hit && reg_rdata == 8'h00)
    else $error("Unmapped read answered");
  chk_mapped_hit:
    assert property (rd && map |=> reg_hit) else $error("Read missed");
  chk_unused_zero:
    assert property (rd && lo inside {7'h1a, 7'h1d, 7'h20} |=>
      reg_rdata[7:6] == 2'b00) else $error("Unused bits read back");
  chk_copy_alias:
    assert property (reg_wr && clk_en && reg_addr == 8'h99 ##1 !reg_wr
      ##1 rd && reg_addr == 8'h19 |=> reg_rdata == $past(reg_wdata, 3))
    else $error("Copy address not aliased");
  chk_quiet_low:
    assert property (clk_en && quiet |=> outs == 3'b000)
    else $error("Output asserted with no source");
  chk_rise_cause:
    assert property ($rose(sequenced_output_six) |-> !$past(quiet))
    else $error("Output rose without cause");
  chk_hit_drop:
    assert property (clk_en && !reg_rd |=> !reg_hit)
    else $error("Hit flag lingered");
  chk_rdata_hold:
    assert property (clk_en && !reg_rd |=> $stable(reg_rdata))
    else $error("Read data moved");
  cover property (rd && map ##1 reg_hit);
  cover property ($rose(sequenced_output_eight));
  cover property (!quiet ##1 outs == 3'b000);
endmodule
bind output_dependency_select output_dependency_select_checker chk (
  .clock, .rst, .clk_en, .reg_wr, .reg_rd, .reg_hit, .reg_addr,
  .reg_wdata, .reg_rdata, .undervoltage, .watchdog_timeout,
  .manual_reset_n, .general_logic_input_n, .sequenced_output_six,
  .sequenced_output_seven, .sequenced_output_eight);

// File: bench/source_model.sv
/* Supplies and reset inputs seen by the block.
 Assumes fault bits: 7:0 detectors, 8 watchdog, 12:9 logic, 13 manual. */
`timescale 1ns/100ps
module source_model (
  input wire logic [13:0] fault,
  output logic [7:0] undervoltage,
  output logic watchdog_timeout,
  output logic [3:0] general_logic_input_n,
  output logic manual_reset_n
);
  assign undervoltage = fault[7:0];
  assign watchdog_timeout = fault[8];
  assign general_logic_input_n = ~fault[12:9];
  assign manual_reset_n = ~fault[13];
endmodule

// File: bench/output_dependency_select_tb_top.sv
/* Testbench for output_dependency_select.
 Assumes byte register port with one-cycle strobes. */
`timescale 1ns/100ps
module output_dependency_select_tb_top;
  logic clock = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, undervoltage;
  logic reg_hit, watchdog_timeout, manual_reset_n;
  logic sequenced_output_six, sequenced_output_seven, sequenced_output_eight;
  wire [7:0] outs = {5'h00, sequenced_output_eight, sequenced_output_seven,
    sequenced_output_six};
  logic [3:0] general_logic_input_n;
  logic [13:0] fault = 14'h0000;
  logic [15:0] sel;
  logic [7:0] base [3] = '{8'h19, 8'h1c, 8'h1f};
  int miscompares = 0, comparisons = 0;
  always #5 clock = ~clock;
  source_model model (.fault, .undervoltage, .watchdog_timeout,
    .general_logic_input_n, .manual_reset_n);
  output_dependency_select dut (.clock, .rst, .clk_en, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .reg_hit, .undervoltage,
    .watchdog_timeout, .general_logic_input_n, .manual_reset_n,
    .sequenced_output_six, .sequenced_output_seven, .sequenced_output_eight);
  task cmp(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clock) reg_wr = 0;
    @(negedge clock);
  endtask
  task rd(logic [7:0] a, logic [7:0] e, logic h);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clock) reg_rd = 0;
    cmp("reg_rdata", e, reg_rdata);
    cmp("reg_hit", {7'h00, h}, {7'h00, reg_hit});
    @(negedge clock);
  endtask
  task wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clock);
    rst = 0;
    for (int i = 0; i < 6; i++) begin
      wr(base[i / 2] + 8'(i % 2) + 8'h80, 8'hff);
      rd(base[i / 2] + 8'(i % 2), (i % 2) ? 8'h3f : 8'hff, 1);
    end
    rd(8'h1b, 8'h00, 0);
    for (int i = 0; i < 6; i++) begin
      wr(base[i / 2] + 8'(i % 2), 8'h00);
    end
    clk_en = 0;
    wr(8'h19, 8'h55);
    clk_en = 1;
    rd(8'h19, 8'h00, 1);
    for (int o = 0; o < 3; o++) begin
      for (int s = 0; s < 14; s++) begin
        sel = 16'(1 << s);
        wr(base[o], sel[7:0]);
        wr(base[o] + 8'h01, sel[15:8]);
        fault = sel[13:0];
        @(negedge clock);
        cmp("outputs", 8'(1 << o), outs);
        fault = ~sel[13:0];
        @(negedge clock);
        cmp("outputs", 8'h00, outs);
        fault = 14'h0000;
      end
      wr(base[o] + 8'h01, 8'h00);
    end
    wrap_up;
  end
  initial begin
    #50000;
    miscompares++;
    wrap_up;
  end
endmodule
